// File: pkg/ufw_consts.svh
// Notes on behaviour
// - Timer failover needs enable and failover mode
// - Only count one-to-zero decrement triggers failover
// - Nonzero count decrements once per microsecond
// - Count stops and holds at zero
// - Zero count triggers nothing until reloaded
// - Software write replaces count immediately
// - Hot reset neither clears nor pauses count
// - New upstream port is the unselected one
// - Count range exceeds one hour
// - Failover: detect, link down, flush, switch, retrain
// - Each failover sets sticky upstream changed flag
// - Same kind dropped while busy, other kind queued
`ifndef UFW_CONSTS_SVH
`define UFW_CONSTS_SVH

`define UFW_ADDR_W        8
`define UFW_DATA_W        32
`define UFW_COUNT_W       32
`define UFW_OFF_CTRL      8'h00
`define UFW_OFF_WDOG      8'h04
`define UFW_OFF_STAT      8'h08
`define UFW_OFF_IRQS      8'h0c
`define UFW_OFF_IRQM      8'h10
`define UFW_OFF_FOCNT     8'h14
`define UFW_CTRL_TFEN     0
`define UFW_STAT_MODE     0
`define UFW_STAT_PORT     1
`define UFW_STAT_CHANGED  2
`define UFW_STAT_BUSY     3
`define UFW_STAT_CAUSE    4
`define UFW_STAT_TPEND    5
`define UFW_STAT_EPEND    6
`define UFW_IRQ_W         3
`define UFW_IRQ_EXPIRE    0
`define UFW_IRQ_START     1
`define UFW_IRQ_DONE      2
`define UFW_FOCNT_W       16
`define UFW_CLK_PERIOD_NS 25
`define UFW_TICK_NS       1000
`define UFW_TICK_CYC      (`UFW_TICK_NS / `UFW_CLK_PERIOD_NS)
`define UFW_PRESC_W       6
`define UFW_FLUSH_CYC     4
`define UFW_FLUSH_W       3

`endif

// File: pkg/ufw_pkg.sv
`include "ufw_consts.svh"

package ufw_pkg;

  typedef enum logic [1:0] {
    UFW_IDLE   = 2'b00,
    UFW_DETECT = 2'b01,
    UFW_SWITCH = 2'b10,
    UFW_TRAIN  = 2'b11
  } ufw_fsm_t;

  typedef enum logic {
    UFW_KIND_TIMER = 1'b0,
    UFW_KIND_EXT   = 1'b1
  } ufw_kind_t;

  typedef struct packed {
    logic [`UFW_PRESC_W-1:0] presc;
    logic [`UFW_COUNT_W-1:0] count;
    logic                    expire;
  } ufw_wd_state_t;

  typedef struct packed {
    logic                    strap_done;
    logic                    fo_mode;
    logic                    cur_port;
    logic                    tfen;
    logic                    changed;
    logic [`UFW_IRQ_W-1:0]   irq_sts;
    logic [`UFW_IRQ_W-1:0]   irq_msk;
    ufw_fsm_t                fsm;
    ufw_kind_t               kind;
    logic                    target;
    logic [`UFW_FLUSH_W-1:0] flush_cnt;
    logic                    tpend;
    logic                    epend;
    logic                    eport;
    logic [`UFW_FOCNT_W-1:0] fo_cnt;
    logic [`UFW_DATA_W-1:0]  rdata;
    logic                    irq;
  } ufw_state_t;

endpackage : ufw_pkg

// File: pkg/ufw_wd_if.sv
`timescale 1ns/1ps
`include "ufw_consts.svh"

interface ufw_wd_if;
  logic                   load;
  logic [`UFW_COUNT_W-1:0] load_val;
  logic [`UFW_COUNT_W-1:0] count;
  logic                   expire;

  modport ctl (output load, output load_val, input count, input expire);
  modport wd  (input load, input load_val, output count, output expire);
endinterface : ufw_wd_if

// File: verification/tb_top.sv
`timescale 1ns/1ps
`include "ufw_consts.svh"

module tb_top;
  logic        clock;
  logic        rst;
  logic        hot;
  logic        mfo;
  logic        mp2;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        irq;
  logic        ext_req;
  logic        ext_port;
  logic        link_up;
  logic        lane;
  logic        retrain;
  logic        busy;
  logic [31:0] v;
  logic [31:0] v2;
  int          num_errors;
  int          checks_done;

  ufw_top i_ufw_top (
    .CLOCK_I(clock), .RST_I(rst), .HOT_RESET_I(hot), .MODE_FAILOVER_I(mfo),
    .MODE_PORT2_I(mp2), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .IRQ_O(irq), .EXT_REQ_I(ext_req), .EXT_PORT_I(ext_port),
    .LINK_UP_I(link_up), .LTSSM_DETECT_O(), .DL_DOWN_O(), .FLUSH_O(),
    .LANE_SEL_O(lane), .RETRAIN_O(retrain), .FAILOVER_BUSY_O(busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'h0;
    forever #12.5 clock = ~clock;
  end

  // Far link comes up one cycle after retraining starts
  always @(posedge clock) begin
    link_up <= retrain;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask : rd_chk

  // Watches busy for n cycles, long enough for a whole failover
  task automatic fo_wait(input int n, input logic exp);
    logic seen;
    seen = 1'h0;
    repeat (n) begin
      @(negedge clock);
      seen = seen | busy;
    end
    @(posedge clock);
    chk({31'h0, seen}, {31'h0, exp});
  endtask : fo_wait

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {hot, mp2, wr, rd, ext_req, ext_port, addr, wdata} = '0;
    rst = 1'h1;
    mfo = 1'h1;
    num_errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    rd_chk(`UFW_OFF_STAT, 32'h1);
    rd_chk(`UFW_OFF_WDOG, 32'h0);
    rd_chk(8'h40, 32'h0);
    wr_reg(`UFW_OFF_WDOG, 32'h64);
    repeat (398) @(posedge clock);
    rd_reg(`UFW_OFF_WDOG, v);
    chk({31'h0, v >= 32'h59 && v <= 32'h5b}, 32'h1);
    repeat (38) @(posedge clock);
    rd_reg(`UFW_OFF_WDOG, v2);
    chk(v2, v - 32'h1);
    wr_reg(`UFW_OFF_WDOG, 32'hffff_ffff);
    rd_reg(`UFW_OFF_WDOG, v);
    chk({31'h0, v >= 32'hffff_fffe}, 32'h1);
    wr_reg(`UFW_OFF_CTRL, 32'h1);
    wr_reg(`UFW_OFF_WDOG, 32'h2);
    fo_wait(150, 1'h1);
    chk({31'h0, lane}, 32'h1);
    rd_chk(`UFW_OFF_STAT, 32'h7);
    rd_chk(`UFW_OFF_WDOG, 32'h0);
    rd_chk(`UFW_OFF_FOCNT, 32'h1);
    rd_chk(`UFW_OFF_IRQS, 32'h7);
    rd_chk(`UFW_OFF_IRQS, 32'h0);
    fo_wait(200, 1'h0);
    wr_reg(`UFW_OFF_WDOG, 32'h3);
    wr_reg(`UFW_OFF_WDOG, 32'h0);
    fo_wait(200, 1'h0);
    for (int i = 0; i < 6; i++) begin
      wr_reg(`UFW_OFF_WDOG, 32'h2);
      fo_wait(28, 1'h0);
    end
    // Last load left running: it expires with hot reset held
    hot <= 1'h1;
    fo_wait(150, 1'h1);
    hot <= 1'h0;
    chk({31'h0, lane}, 32'h0);
    rd_chk(`UFW_OFF_STAT, 32'h5);
    wr_reg(`UFW_OFF_STAT, 32'h4);
    rd_chk(`UFW_OFF_STAT, 32'h1);
    rd_reg(`UFW_OFF_IRQS, v);
    wr_reg(`UFW_OFF_CTRL, 32'h0);
    wr_reg(`UFW_OFF_IRQM, 32'h2);
    wr_reg(`UFW_OFF_WDOG, 32'h1);
    fo_wait(100, 1'h0);
    chk({31'h0, irq}, 32'h0);
    wr_reg(`UFW_OFF_IRQM, 32'h1);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    rd_chk(`UFW_OFF_IRQS, 32'h1);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    @(posedge clock);
    ext_port <= 1'h1;
    ext_req <= 1'h1;
    @(posedge clock);
    ext_req <= 1'h0;
    fo_wait(60, 1'h1);
    rd_chk(`UFW_OFF_STAT, 32'h17);
    wr_reg(`UFW_OFF_CTRL, 32'h1);
    wr_reg(`UFW_OFF_WDOG, 32'h1);
    // Other-kind request lands while the timer failover runs
    do begin
      @(negedge clock);
    end while (!busy);
    @(posedge clock);
    ext_req <= 1'h1;
    @(posedge clock);
    ext_req <= 1'h0;
    rd_chk(`UFW_OFF_STAT, 32'h4f);
    fo_wait(60, 1'h1);
    rd_chk(`UFW_OFF_STAT, 32'h17);
    rd_chk(`UFW_OFF_FOCNT, 32'h5);
    @(posedge clock);
    rst <= 1'h1;
    mfo <= 1'h0;
    mp2 <= 1'h1;
    repeat (20) @(posedge clock);
    rst <= 1'h0;
    wr_reg(`UFW_OFF_CTRL, 32'h1);
    wr_reg(`UFW_OFF_WDOG, 32'h1);
    fo_wait(100, 1'h0);
    rd_chk(`UFW_OFF_STAT, 32'h2);
    chk({31'h0, lane}, 32'h1);
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    wrap_up();
  end
endmodule : tb_top

// File: verification/ufw_top_assertions.sv
`timescale 1ns/1ps
`include "ufw_consts.svh"

module ufw_top_assertions (
  input wire logic                   CLOCK_I,          // Clock
  input wire logic                   RST_I,            // Reset
  input wire logic                   HOT_RESET_I,      // Hot reset
  input wire logic                   MODE_FAILOVER_I,  // Strap
  input wire logic                   RD_I,             // Read
  input wire logic [`UFW_DATA_W-1:0] RDATA_O,          // Data
  input wire logic                   LINK_UP_I,        // Link up
  input wire logic                   LTSSM_DETECT_O,   // Detect
  input wire logic                   DL_DOWN_O,        // Link down
  input wire logic                   FLUSH_O,          // Flush
  input wire logic                   LANE_SEL_O,       // Lane
  input wire logic                   RETRAIN_O,        // Retrain
  input wire logic                   FAILOVER_BUSY_O   // Busy
);
  logic first_q;
  logic mode_q;

  // Own copy of the strap, taken at the same edge as the design
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      first_q <= 1'h1;
    end else begin
      first_q <= 1'h0;
      if (first_q) begin
        mode_q <= MODE_FAILOVER_I;
      end
    end
  end

  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);

  property p_mode_gate;
    !first_q && !mode_q |-> !FAILOVER_BUSY_O;
  endproperty
  a_mode_gate: assert property (p_mode_gate)
    else $error("Failover outside failover mode");
  property p_seq;
    $rose(FLUSH_O) |-> (FLUSH_O && DL_DOWN_O)[*4] ##1 (!FLUSH_O && LTSSM_DETECT_O)
      ##1 (RETRAIN_O && !DL_DOWN_O);
  endproperty
  a_seq: assert property (p_seq)
    else $error("Failover step order wrong");
  property p_lane;
    !$past(RST_I, 2) && $changed(LANE_SEL_O) |-> RETRAIN_O && $past(DL_DOWN_O);
  endproperty
  a_lane: assert property (p_lane)
    else $error("Lane switched outside failover");
  property p_busy;
    FAILOVER_BUSY_O == (DL_DOWN_O || RETRAIN_O);
  endproperty
  a_busy: assert property (p_busy)
    else $error("Busy does not match sequence");
  property p_train_hold;
    RETRAIN_O && !LINK_UP_I |=> RETRAIN_O;
  endproperty
  a_train_hold: assert property (p_train_hold)
    else $error("Retrain dropped before link up");
  property p_train_end;
    RETRAIN_O && LINK_UP_I |=> !RETRAIN_O;
  endproperty
  a_train_end: assert property (p_train_end)
    else $error("Retrain held after link up");
  property p_hot;
    HOT_RESET_I && DL_DOWN_O |=> FAILOVER_BUSY_O;
  endproperty
  a_hot: assert property (p_hot)
    else $error("Hot reset stopped failover");
  property p_rdata;
    !RD_I |=> RDATA_O == '0;
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("Read data outside slot");

  c_fo: cover property ($rose(FLUSH_O));
  c_link: cover property (RETRAIN_O && LINK_UP_I);
  c_hot: cover property (HOT_RESET_I && FAILOVER_BUSY_O);
endmodule : ufw_top_assertions

bind ufw_top ufw_top_assertions i_ufw_top_assertions (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .HOT_RESET_I(HOT_RESET_I),
  .MODE_FAILOVER_I(MODE_FAILOVER_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .LINK_UP_I(LINK_UP_I), .LTSSM_DETECT_O(LTSSM_DETECT_O), .DL_DOWN_O(DL_DOWN_O),
  .FLUSH_O(FLUSH_O), .LANE_SEL_O(LANE_SEL_O), .RETRAIN_O(RETRAIN_O),
  .FAILOVER_BUSY_O(FAILOVER_BUSY_O)
);

// File: verilog/ufw_top.sv
// Decided for this implementation: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "ufw_consts.svh"

module ufw_top (
  input  wire logic                   CLOCK_I,          // Core clock
  input  wire logic                   RST_I,            // Fundamental reset
  input  wire logic                   HOT_RESET_I,      // Hot reset level
  input  wire logic                   MODE_FAILOVER_I,  // Strap: failover mode
  input  wire logic                   MODE_PORT2_I,     // Strap: start on port 2
  input  wire logic [`UFW_ADDR_W-1:0] ADDR_I,           // Register address
  input  wire logic [`UFW_DATA_W-1:0] WDATA_I,          // Register write data
  input  wire logic                   WR_I,             // Write strobe
  input  wire logic                   RD_I,             // Read strobe
  output logic      [`UFW_DATA_W-1:0] RDATA_O,          // Read data, next cycle
  output logic                        IRQ_O,            // Interrupt level
  input  wire logic                   EXT_REQ_I,        // Other-kind failover pulse
  input  wire logic                   EXT_PORT_I,       // Port asked by EXT_REQ_I
  input  wire logic                   LINK_UP_I,        // Upstream link trained
  output logic                        LTSSM_DETECT_O,   // Force LTSSM to Detect
  output logic                        DL_DOWN_O,        // Force data link down
  output logic                        FLUSH_O,          // Discard queue and replay
  output logic                        LANE_SEL_O,       // Lane mux: 0 port 0, 1 port 2
  output logic                        RETRAIN_O,        // Start link training
  output logic                        FAILOVER_BUSY_O   // Failover in progress
);

  ufw_pkg::ufw_state_t s_q;
  ufw_pkg::ufw_state_t s_d;

  ufw_wd_if wd_if ();

  ufw_wdog u_wdog (
    .clk_i (CLOCK_I),
    .rst_i (RST_I),
    .wd    (wd_if.wd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic wr_ctrl;
  logic wr_wdog;
  logic wr_stat;
  logic wr_irqm;
  logic rd_irqs;

  assign wr_ctrl = WR_I && (ADDR_I == `UFW_OFF_CTRL);
  assign wr_wdog = WR_I && (ADDR_I == `UFW_OFF_WDOG);
  assign wr_stat = WR_I && (ADDR_I == `UFW_OFF_STAT);
  assign wr_irqm = WR_I && (ADDR_I == `UFW_OFF_IRQM);
  assign rd_irqs = RD_I && (ADDR_I == `UFW_OFF_IRQS);

  // A write replaces the running count in the same edge
  assign wd_if.load     = wr_wdog;
  assign wd_if.load_val = WDATA_I;

  ////////////////////////////////////////////////////////////////////////////
  // Request arbitration

  logic                  timer_req;
  logic                  ext_req;
  logic                  busy;
  logic                  start_t;
  logic                  start_e;
  logic                  start_e_port;
  logic                  from_tpend;
  logic                  from_epend;
  logic                  done_ev;
  logic [`UFW_IRQ_W-1:0] irq_ev;

  // Count expiry only counts when enabled and strapped for failover
  assign timer_req = wd_if.expire && s_q.tfen && s_q.fo_mode;
  assign ext_req   = EXT_REQ_I && s_q.fo_mode;
  assign busy      = (s_q.fsm != ufw_pkg::UFW_IDLE);

  always_comb begin
    start_t      = 1'b0;
    start_e      = 1'b0;
    start_e_port = 1'b0;
    from_tpend   = 1'b0;
    from_epend   = 1'b0;
    if (!busy) begin
      if (s_q.epend) begin
        from_epend   = 1'b1;
        start_e      = (s_q.eport != s_q.cur_port);
        start_e_port = s_q.eport;
      end else if (s_q.tpend) begin
        from_tpend = 1'b1;
        start_t    = 1'b1;
      end else if (timer_req) begin
        start_t = 1'b1;
      end else if (ext_req) begin
        start_e      = (EXT_PORT_I != s_q.cur_port);
        start_e_port = EXT_PORT_I;
      end
    end
  end

  assign done_ev = (s_q.fsm == ufw_pkg::UFW_TRAIN) && LINK_UP_I;

  always_comb begin
    irq_ev                  = '0;
    irq_ev[`UFW_IRQ_EXPIRE] = wd_if.expire;
    irq_ev[`UFW_IRQ_START]  = start_t || start_e;
    irq_ev[`UFW_IRQ_DONE]   = done_ev;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d       = s_q;
    s_d.rdata = '0;

    // Straps are caught on the first edge after reset release
    if (!s_q.strap_done) begin
      s_d.strap_done = 1'b1;
      s_d.fo_mode    = MODE_FAILOVER_I;
      s_d.cur_port   = MODE_PORT2_I;
    end

    if (wr_ctrl) begin
      s_d.tfen = WDATA_I[`UFW_CTRL_TFEN];
    end
    if (wr_irqm) begin
      s_d.irq_msk = WDATA_I[`UFW_IRQ_W-1:0];
    end
    if (wr_stat && WDATA_I[`UFW_STAT_CHANGED]) begin
      s_d.changed = 1'b0;
    end

    // Pending queue: a kind already active or pending is dropped
    if (from_tpend) begin
      s_d.tpend = 1'b0;
    end
    if (from_epend) begin
      s_d.epend = 1'b0;
    end
    if (timer_req && !(start_t && !from_tpend)) begin
      if (!(busy && (s_q.kind == ufw_pkg::UFW_KIND_TIMER)) && !from_tpend) begin
        s_d.tpend = 1'b1;
      end
    end
    if (ext_req && !(start_e && !from_epend)) begin
      if (!(busy && (s_q.kind == ufw_pkg::UFW_KIND_EXT)) && !s_q.epend) begin
        s_d.epend = 1'b1;
        s_d.eport = EXT_PORT_I;
      end
    end

    case (s_q.fsm)
      ufw_pkg::UFW_IDLE: begin
        s_d.flush_cnt = '0;
        if (start_t) begin
          s_d.fsm    = ufw_pkg::UFW_DETECT;
          s_d.kind   = ufw_pkg::UFW_KIND_TIMER;
          s_d.target = !s_q.cur_port;
        end else if (start_e) begin
          s_d.fsm    = ufw_pkg::UFW_DETECT;
          s_d.kind   = ufw_pkg::UFW_KIND_EXT;
          s_d.target = start_e_port;
        end
      end
      ufw_pkg::UFW_DETECT: begin
        // Link held down while queued and replay data drain away
        if (s_q.flush_cnt == `UFW_FLUSH_W'(`UFW_FLUSH_CYC - 1)) begin
          s_d.fsm = ufw_pkg::UFW_SWITCH;
        end else begin
          s_d.flush_cnt = s_q.flush_cnt + `UFW_FLUSH_W'(1);
        end
      end
      ufw_pkg::UFW_SWITCH: begin
        s_d.cur_port = s_q.target;
        s_d.changed  = 1'b1;
        s_d.fo_cnt   = s_q.fo_cnt + `UFW_FOCNT_W'(1);
        s_d.fsm      = ufw_pkg::UFW_TRAIN;
      end
      ufw_pkg::UFW_TRAIN: begin
        if (LINK_UP_I) begin
          s_d.fsm = ufw_pkg::UFW_IDLE;
        end
      end
      default: begin
        s_d.fsm = ufw_pkg::UFW_IDLE;
      end
    endcase

    // Interrupt status: read clears, a new event in the same cycle wins
    if (rd_irqs || HOT_RESET_I) begin
      s_d.irq_sts = irq_ev;
    end else begin
      s_d.irq_sts = s_q.irq_sts | irq_ev;
    end
    if (HOT_RESET_I) begin
      s_d.irq_msk = '0;
    end
    s_d.irq = |(s_d.irq_sts & s_d.irq_msk);

    // Read data stands in the cycle after the strobe
    if (RD_I) begin
      case (ADDR_I)
        `UFW_OFF_CTRL: begin
          s_d.rdata[`UFW_CTRL_TFEN] = s_q.tfen;
        end
        `UFW_OFF_WDOG: begin
          s_d.rdata = wd_if.count;
        end
        `UFW_OFF_STAT: begin
          s_d.rdata[`UFW_STAT_MODE]    = s_q.fo_mode;
          s_d.rdata[`UFW_STAT_PORT]    = s_q.cur_port;
          s_d.rdata[`UFW_STAT_CHANGED] = s_q.changed;
          s_d.rdata[`UFW_STAT_BUSY]    = busy;
          s_d.rdata[`UFW_STAT_CAUSE]   = s_q.kind;
          s_d.rdata[`UFW_STAT_TPEND]   = s_q.tpend;
          s_d.rdata[`UFW_STAT_EPEND]   = s_q.epend;
        end
        `UFW_OFF_IRQS: begin
          s_d.rdata[`UFW_IRQ_W-1:0] = s_q.irq_sts;
        end
        `UFW_OFF_IRQM: begin
          s_d.rdata[`UFW_IRQ_W-1:0] = s_q.irq_msk;
        end
        `UFW_OFF_FOCNT: begin
          s_d.rdata[`UFW_FOCNT_W-1:0] = s_q.fo_cnt;
        end
        default: begin
          s_d.rdata = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Hot reset leaves this register alone except as coded above
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign RDATA_O         = s_q.rdata;
  assign IRQ_O           = s_q.irq;
  assign LANE_SEL_O      = s_q.cur_port;
  assign FAILOVER_BUSY_O = busy;
  assign LTSSM_DETECT_O  = (s_q.fsm == ufw_pkg::UFW_DETECT) ||
                           (s_q.fsm == ufw_pkg::UFW_SWITCH);
  assign DL_DOWN_O       = (s_q.fsm == ufw_pkg::UFW_DETECT) ||
                           (s_q.fsm == ufw_pkg::UFW_SWITCH);
  assign FLUSH_O         = (s_q.fsm == ufw_pkg::UFW_DETECT);
  assign RETRAIN_O       = (s_q.fsm == ufw_pkg::UFW_TRAIN);

endmodule : ufw_top

// File: verilog/ufw_wdog.sv
`timescale 1ns/1ps
`include "ufw_consts.svh"

module ufw_wdog (
  input  wire logic clk_i,  // Core clock
  input  wire logic rst_i,  // Fundamental reset, sync, high
  ufw_wd_if.wd      wd      // Load port and count status
);

  ufw_pkg::ufw_wd_state_t s_q;
  ufw_pkg::ufw_wd_state_t s_d;
  logic                   tick;

  ////////////////////////////////////////////////////////////////////////////
  // Microsecond prescaler and count

  always_comb begin
    s_d        = s_q;
    s_d.expire = 1'b0;
    tick       = (s_q.presc == `UFW_PRESC_W'(`UFW_TICK_CYC - 1));
    if (tick) begin
      s_d.presc = '0;
    end else begin
      s_d.presc = s_q.presc + `UFW_PRESC_W'(1);
    end
    if (wd.load) begin
      s_d.count = wd.load_val;
    end else if (tick && (s_q.count != '0)) begin
      s_d.count = s_q.count - `UFW_COUNT_W'(1);
      if (s_q.count == `UFW_COUNT_W'(1)) begin
        s_d.expire = 1'b1;
      end
    end
  end

  // Hot reset is not an input here, so the count runs through it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wd.count  = s_q.count;
  assign wd.expire = s_q.expire;

endmodule : ufw_wdog
